// *** rtl/correlator_dump_frame_formatter.v ***
`timescale 1ns/10ps
`include "dump_frame_regs.vh"

module correlator_dump_frame_formatter
  #(
  parameter BOARD_ID_W = 10
  )
  (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Register port
  input  wire [5:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Lag data read port
  output reg  [7:0]  lag_addr,
  output reg         lag_src_chip,
  input  wire [31:0] lag_data,
  // Scheduler
  input  wire        tx_enable,
  output reg         tx_done,
  // Link transmit side
  input  wire        link_clk_in,
  output reg  [31:0] link_data,
  output reg         link_valid,
  output reg         link_drive_en
  );

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 4'b0001;
  localparam S_WAIT = 4'b0010;
  localparam S_SEND = 4'b0100;
  localparam S_DONE = 4'b1000;

  reg  [3:0]            state;
  reg  [8:0]            idx;
  reg  [31:0]           csum;
  reg                   fast;
  reg  [15:0]           frame_count;

  reg  [BOARD_ID_W-1:0] board_id;
  reg  [31:0]           ident;
  reg  [3:0]            cross_correlator_index;
  reg  [5:0]            correlator_chip_index;
  reg  [3:0]            x_harmonic_phase_offset;
  reg  [3:0]            y_harmonic_phase_offset;
  reg  [15:0]           bin_number;
  reg  [8:0]            dump_count;
  reg  [7:0]            x_delay_block_count;
  reg  [7:0]            y_delay_block_count;
  reg  [31:0]           centre_valid_sample_count;
  reg  [31:0]           edge_valid_sample_count;
  reg  [31:0]           data_bias;
  reg  [31:0]           epoch_seconds;
  reg  [2:0]            epoch_code;
  reg  [28:0]           sample_count;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg  link_meta;
  reg  link_sync;
  reg  link_prev;
  reg  en_meta;
  reg  en_sync;
  wire link_edge;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      link_prev <= 1'b0;
      en_meta   <= 1'b0;
      en_sync   <= 1'b0;
    end
    else
    begin
      link_meta <= link_clk_in;
      link_sync <= link_meta;
      link_prev <= link_sync;
      en_meta   <= tx_enable;
      en_sync   <= en_meta;
    end
  end

  // Rising link clock seen in the local domain
  assign link_edge = link_sync & ~link_prev;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  wire go_write;

  assign go_write = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_GO_BIT];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      board_id                  <= {BOARD_ID_W{1'b0}};
      ident                     <= 32'h00000000;
      cross_correlator_index    <= 4'h0;
      correlator_chip_index     <= 6'h00;
      x_harmonic_phase_offset   <= 4'h0;
      y_harmonic_phase_offset   <= 4'h0;
      bin_number                <= 16'h0000;
      dump_count                <= 9'h000;
      x_delay_block_count       <= 8'h00;
      y_delay_block_count       <= 8'h00;
      centre_valid_sample_count <= 32'h00000000;
      edge_valid_sample_count   <= 32'h00000000;
      data_bias                 <= 32'h00000000;
      epoch_seconds             <= 32'h00000000;
      epoch_code                <= `EPOCH_1970;
      sample_count              <= 29'h00000000;
    end
    else if (reg_wr)
    begin
      // Header contents may be updated while a frame is sent; the
      // producer should write them only while idle
      case (reg_addr)
        `REG_BOARD:
          board_id <= reg_wdata[BOARD_ID_W-1:0];
        `REG_IDENT:
          ident <= reg_wdata;
        `REG_SOURCE:
        begin
          cross_correlator_index  <= reg_wdata[3:0];
          correlator_chip_index   <= reg_wdata[9:4];
          x_harmonic_phase_offset <= reg_wdata[19:16];
          y_harmonic_phase_offset <= reg_wdata[23:20];
        end
        `REG_BIN:
        begin
          bin_number <= reg_wdata[15:0];
          dump_count <= reg_wdata[24:16];
        end
        `REG_DELAY:
        begin
          x_delay_block_count <= reg_wdata[7:0];
          y_delay_block_count <= reg_wdata[15:8];
        end
        `REG_CENTRE:
          centre_valid_sample_count <= reg_wdata;
        `REG_EDGE:
          edge_valid_sample_count <= reg_wdata;
        `REG_BIAS:
          data_bias <= reg_wdata;
        `REG_SECONDS:
          epoch_seconds <= reg_wdata;
        `REG_SAMPLES:
        begin
          sample_count <= reg_wdata[28:0];
          epoch_code   <= reg_wdata[31:29];
        end
        default:
          board_id <= board_id;
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  reg [31:0] next_rdata;

  always @*
  begin
    case (reg_addr)
      `REG_CTRL:
        next_rdata = {frame_count, 14'h0000, fast, (state != S_IDLE)};
      `REG_BOARD:
        next_rdata = {{(32-BOARD_ID_W){1'b0}}, board_id};
      `REG_IDENT:
        next_rdata = ident;
      `REG_SOURCE:
        next_rdata = {8'h00, y_harmonic_phase_offset, x_harmonic_phase_offset,
                      6'h00, correlator_chip_index, cross_correlator_index};
      `REG_BIN:
        next_rdata = {7'h00, dump_count, bin_number};
      `REG_DELAY:
        next_rdata = {16'h0000, y_delay_block_count, x_delay_block_count};
      `REG_CENTRE:
        next_rdata = centre_valid_sample_count;
      `REG_EDGE:
        next_rdata = edge_valid_sample_count;
      `REG_BIAS:
        next_rdata = data_bias;
      `REG_SECONDS:
        next_rdata = epoch_seconds;
      `REG_SAMPLES:
        next_rdata = {epoch_code, sample_count};
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  // Zero outside the answer cycle, so a stale word is never taken
  // for fresh read data
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h00000000;
  end

  // ----------------------------------------
  // Word builder
  // ----------------------------------------
  reg [31:0] word;

  always @*
  begin
    case (idx)
      9'h000:
        word = `SYNC_START;
      9'h001:
        if (fast)
          word = {11'h000, correlator_chip_index, cross_correlator_index,
                  y_harmonic_phase_offset, x_harmonic_phase_offset,
                  `TYPE_FAST};
        else
          word = {bin_number, 3'h0, correlator_chip_index,
                  cross_correlator_index, `TYPE_ACCUM};
      9'h002:
        word = ident;
      9'h003:
        if (fast)
          word = {bin_number, y_delay_block_count, x_delay_block_count};
        else
          word = {7'h00, dump_count, y_delay_block_count,
                  x_delay_block_count};
      9'h004:
        word = centre_valid_sample_count;
      9'h005:
        word = edge_valid_sample_count;
      9'h006:
        word = fast ? data_bias : 32'h00000000;
      9'h007:
        word = epoch_seconds;
      9'h008:
        word = {epoch_code, sample_count};
      `IDX_SYNC_END:
        word = {`SYNC_END_HIGH, board_id};
      `IDX_CHECKSUM:
        word = csum;
      default:
        word = lag_data;
    endcase
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  wire [8:0] idx_plus;
  wire [8:0] lag_index;

  assign idx_plus  = idx + 9'h001;
  // Address leads the word by a whole link period, so the one-cycle
  // read latency is hidden behind the eight-cycle link clock
  assign lag_index = idx_plus - `IDX_LAG_FIRST;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= S_IDLE;
      idx           <= 9'h000;
      csum          <= 32'h00000000;
      fast          <= 1'b0;
      frame_count   <= 16'h0000;
      lag_addr      <= 8'h00;
      lag_src_chip  <= 1'b0;
      tx_done       <= 1'b0;
      link_data     <= 32'h00000000;
      link_valid    <= 1'b0;
      link_drive_en <= 1'b0;
    end
    else
    begin
      tx_done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          idx  <= 9'h000;
          csum <= 32'h00000000;
          if (go_write)
          begin
            fast         <= reg_wdata[`CTRL_FAST_BIT];
            lag_src_chip <= reg_wdata[`CTRL_FAST_BIT];
            state        <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (en_sync)
          begin
            link_drive_en <= 1'b1;
            state         <= S_SEND;
          end
        end
        S_SEND:
        begin
          if (link_edge)
          begin
            // Once started, the frame runs to the end even if the
            // enable drops: no gaps, no partial frames
            if (idx == `FRAME_WORDS)
            begin
              link_valid <= 1'b0;
              state      <= S_DONE;
            end
            else
            begin
              link_data  <= word;
              link_valid <= 1'b1;
              if (idx != `IDX_CHECKSUM)
                csum <= csum + word;
              idx        <= idx_plus;
              lag_addr   <= lag_index[7:0];
            end
          end
        end
        S_DONE:
        begin
          // Drivers released with the done pulse, so the scheduler can
          // hand the link to the next sender at once
          tx_done       <= 1'b1;
          link_drive_en <= 1'b0;
          frame_count   <= frame_count + 16'h0001;
          state         <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

endmodule

// *** rtl/dump_frame_regs.vh ***
`ifndef DUMP_FRAME_REGS_VH
`define DUMP_FRAME_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define REG_CTRL        6'h00
`define REG_BOARD       6'h04
`define REG_IDENT       6'h08
`define REG_SOURCE      6'h0C
`define REG_BIN         6'h10
`define REG_DELAY       6'h14
`define REG_CENTRE      6'h18
`define REG_EDGE        6'h1C
`define REG_BIAS        6'h20
`define REG_SECONDS     6'h24
`define REG_SAMPLES     6'h28

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define CTRL_GO_BIT     0
`define CTRL_FAST_BIT   1
`define STAT_BUSY_BIT   0
`define STAT_FAST_BIT   1

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define FRAME_WORDS     9'h10A
`define IDX_LAG_FIRST   9'h009
`define IDX_SYNC_END    9'h108
`define IDX_CHECKSUM    9'h109
`define SYNC_START      32'h55555555
`define SYNC_END_HIGH   22'h1C71C7
`define TYPE_ACCUM      3'h4
`define TYPE_FAST       3'h3
`define EPOCH_1970      3'h0
`define LINK_PERIOD_NS  400
`define CLK_PERIOD_NS   50

`endif

// *** bench/frame_props.sv ***
`timescale 1ns/10ps
module frame_props (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Observed outputs
  input wire        tx_done,
  input wire [31:0] link_data,
  input wire        link_valid,
  input wire        link_drive_en
);
  // ----
  // Frame tracking
  // ----
  reg [31:0] sum_b;
  reg [31:0] last_d;
  reg [31:0] prev_w;
  reg [8:0]  words;
  reg        last_v;
  // Counts a word on each change, so equal neighbours would be missed
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sum_b <= 32'h0;
      last_d <= 32'h0;
      prev_w <= 32'h0;
      words <= 9'h0;
      last_v <= 1'b0;
    end
    else
    begin
      last_d <= link_data;
      last_v <= link_valid;
      if (link_valid && !last_v)
      begin
        sum_b <= 32'h0;
        words <= 9'h1;
      end
      else if (link_valid && link_data != last_d)
      begin
        sum_b <= sum_b + last_d;
        prev_w <= last_d;
        words <= words + 9'h1;
      end
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_done_pulse; tx_done |=> !tx_done; endproperty
  property p_done_after; $fell(link_valid) |-> ##[0:2] tx_done; endproperty
  property p_done_idle; tx_done |-> !link_valid && !link_drive_en; endproperty
  property p_sync_first; $rose(link_valid) |-> link_data == 32'h55555555; endproperty
  property p_in_drive; link_valid |-> link_drive_en; endproperty
  property p_hold; link_valid && $changed(link_data) |=> $stable(link_data)[*5]; endproperty
  property p_count; $fell(link_valid) |-> $past(words) == 9'h10A; endproperty
  property p_sum; $fell(link_valid) |-> $past(link_data) == $past(sum_b); endproperty
  property p_end_sync; $fell(link_valid) |-> $past(prev_w[31:10]) == 22'h1C71C7; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done wider than one cycle");
  a_done_after: assert property (p_done_after) else $error("no done after frame");
  a_done_idle: assert property (p_done_idle) else $error("done while sending");
  a_sync_first: assert property (p_sync_first) else $error("frame not opened by sync");
  a_in_drive: assert property (p_in_drive) else $error("word outside drive window");
  a_hold: assert property (p_hold) else $error("word held too briefly");
  a_count: assert property (p_count) else $error("wrong word count");
  a_sum: assert property (p_sum) else $error("checksum mismatch");
  a_end_sync: assert property (p_end_sync) else $error("bad end sync word");
  c_frame: cover property ($fell(link_valid));
  c_done: cover property (tx_done);
  c_start: cover property ($rose(link_drive_en));
endmodule

// *** bench/link_receiver.sv ***
`timescale 1ns/10ps
module link_receiver (
  // Link clock
  output reg         link_clk,
  // Transmit side of the block
  input  wire [31:0] link_data,
  input  wire        link_valid,
  input  wire        link_drive_en
);
  reg [31:0] words [0:265];
  integer    count;
  // Phase unrelated to clk
  initial
  begin
    link_clk = 1'b0;
    #137;
    forever #200 link_clk = ~link_clk;
  end
  // Sampled at the rising edge, before the next word is launched
  always @(posedge link_clk)
  begin
    if (!link_drive_en)
      count <= 0;
    else if (link_valid && count < 266)
    begin
      words[count] <= link_data;
      count <= count + 1;
    end
  end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`include "dump_frame_regs.vh"
module tb_top;
  reg         clk, rst_n, reg_wr, reg_rd, tx_enable;
  reg  [5:0]  reg_addr;
  reg  [31:0] reg_wdata, lag_data, d, t, sum;
  reg  [31:0] exp_w [0:265];
  wire [31:0] reg_rdata, link_data;
  wire [7:0]  lag_addr;
  wire        lag_src_chip, tx_done, link_clk, link_valid, link_drive_en;
  integer     fails, total_checks, i, n;
  // ----
  // Design and far side
  // ----
  correlator_dump_frame_formatter dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lag_addr(lag_addr), .lag_src_chip(lag_src_chip), .lag_data(lag_data),
    .tx_enable(tx_enable), .tx_done(tx_done), .link_clk_in(link_clk),
    .link_data(link_data), .link_valid(link_valid), .link_drive_en(link_drive_en));
  link_receiver rx (.link_clk(link_clk), .link_data(link_data), .link_valid(link_valid),
    .link_drive_en(link_drive_en));
  always #25 clk = ~clk;
  // Source and lag index visible in every lag word
  always @(posedge clk) lag_data <= {lag_src_chip, 7'h2B, 16'h0, lag_addr};
  // ----
  // Tasks
  // ----
  task report_and_stop;
  begin
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task chk(input [31:0] seen, input [31:0] want);
  begin
    total_checks = total_checks + 1;
    if (seen !== want)
    begin
      fails = fails + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  end
  endtask
  task wr(input [5:0] a, input [31:0] v);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [5:0] a);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  end
  endtask
  task wait_done;
  begin
    for (n = 0; n < 4000 && tx_done !== 1'b1; n = n + 1)
      @(negedge clk);
    if (n == 4000)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  endtask
  task check_frame(input fast);
  begin
    exp_w[0] = `SYNC_START;
    exp_w[1] = fast ? {11'h0, 6'h2D, 4'hB, 4'h9, 4'h6, `TYPE_FAST}
                    : {16'h8123, 3'h0, 6'h2D, 4'hB, `TYPE_ACCUM};
    exp_w[2] = 32'h8A4C1203;
    exp_w[3] = fast ? 32'h8123C417 : 32'h01A5C417;
    exp_w[4] = 32'h00ABCDEF;
    exp_w[5] = 32'h00ABCD01;
    exp_w[6] = fast ? 32'hFFFFF3A0 : 32'h0;
    exp_w[7] = 32'h3B9ACA07;
    exp_w[8] = 32'h00FEDCBA;
    for (i = 9; i < 264; i = i + 1)
    begin
      t = i - 9;
      exp_w[i] = {fast, 7'h2B, 16'h0, t[7:0]};
    end
    exp_w[264] = {`SYNC_END_HIGH, 10'h2A5};
    sum = 32'h0;
    for (i = 0; i < 265; i = i + 1)
      sum = sum + exp_w[i];
    exp_w[265] = sum;
    chk(rx.count, 32'd266);
    for (i = 0; i < 9; i = i + 1)
      chk(rx.words[i], exp_w[i]);
    for (i = 9; i < 264; i = i + 1)
      chk(rx.words[i], exp_w[i]);
    for (i = 264; i < 266; i = i + 1)
      chk(rx.words[i], exp_w[i]);
  end
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, tx_enable} = 3'h0;
    reg_addr = 6'h0;
    reg_wdata = 32'h0;
    fails = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`REG_CTRL);
    chk(d, 32'h0);
    wr(6'h30, 32'hFFFFFFFF);
    rd(6'h30);
    chk(d, 32'h0);
    wr(`REG_BOARD, 32'h2A5);
    wr(`REG_IDENT, 32'h8A4C1203);
    wr(`REG_SOURCE, 32'h009602DB);
    wr(`REG_BIN, 32'h01A58123);
    wr(`REG_DELAY, 32'h0000C417);
    wr(`REG_CENTRE, 32'h00ABCDEF);
    wr(`REG_EDGE, 32'h00ABCD01);
    wr(`REG_BIAS, 32'hFFFFF3A0);
    wr(`REG_SECONDS, 32'h3B9ACA07);
    wr(`REG_SAMPLES, 32'h00FEDCBA);
    rd(`REG_BOARD);
    chk(d, 32'h2A5);
    @(posedge clk);
    tx_enable <= 1'b1;
    wr(`REG_CTRL, 32'h1);
    rd(`REG_CTRL);
    chk(d & 32'h3, 32'h1);
    // Enable drop and a second go mid-frame must both be ignored
    repeat (800) @(posedge clk);
    tx_enable <= 1'b0;
    wr(`REG_CTRL, 32'h3);
    wait_done;
    check_frame(1'b0);
    @(posedge clk);
    tx_enable <= 1'b1;
    repeat (100) @(negedge clk);
    chk({31'h0, link_drive_en}, 32'h0);
    wr(`REG_CTRL, 32'h3);
    wait_done;
    check_frame(1'b1);
    rd(`REG_CTRL);
    chk(d & 32'hFFFF0003, 32'h00020002);
    report_and_stop;
  end
endmodule
bind correlator_dump_frame_formatter frame_props u_props (.clk(clk), .rst_n(rst_n),
  .tx_done(tx_done), .link_data(link_data), .link_valid(link_valid),
  .link_drive_en(link_drive_en));
